/* hdl/cdr_ctrl_regs.sv */
// Codec DAC and ADC control registers with soft mute and gain ramps.
`timescale 1ns/10ps
module cdr_ctrl_regs (
  // Clock, enable and reset.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Control port.
  input wire logic ctl_valid,
  input wire cdr_pkg::cdr_ctl_word_s ctl_word,
  input wire logic rd_valid,
  input wire logic [7:0] rd_index,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // Sample timing and datapath status.
  input wire logic fs_tick,
  input wire logic [1:0] sysclk_ratio,
  input wire logic zero_cross_disable,
  input wire logic [1:0] adc_zero_cross,
  input wire logic [1:0] dac_zero_detect,
  input wire logic [7:0] dac_att_left,
  input wire logic [7:0] dac_att_right,
  // DAC controls.
  output logic [1:0] dac_osr_code,
  output logic dac_phase_invert,
  output logic dac_left_soft_mute,
  output logic dac_right_soft_mute,
  output logic [7:0] dac_left_level,
  output logic [7:0] dac_right_level,
  output logic filter_rolloff_select,
  output logic deemph_enable,
  output logic [1:0] deemph_rate_select,
  output logic left_zero_flag,
  output logic right_zero_flag,
  // ADC controls.
  output logic [7:0] adc_left_level,
  output logic [7:0] adc_right_level,
  output logic adc_ramp_busy,
  output logic adc_clock_set_select,
  output logic [2:0] adc_if_mode,
  output logic adc_master
);
  typedef struct packed {
    logic [cdr_pkg::REG_COUNT-1:0][7:0] regs;
    logic [2:0] div8;
    logic [1:0][9:0] nozc;
    logic [1:0][7:0] dac_prev;
    logic [1:0] zflag;
    logic [1:0] osr;
    logic [1:0] rate;
    logic master;
    logic [7:0] rd_data;
    logic rd_hit;
  } cdr_top_s;

  function automatic logic reg_mapped(input logic [7:0] idx);
    reg_mapped = (idx >= cdr_pkg::REG_BASE) && (idx <= cdr_pkg::REG_ADC_CLK);
  endfunction : reg_mapped

  function automatic logic [2:0] reg_slot(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - cdr_pkg::REG_BASE;
    reg_slot = off[2:0];
  endfunction : reg_slot

  logic [1:0] rst_sync_q;
  logic rst_n;
  cdr_top_s q, d;
  logic [1:0][7:0] dac_tgt;
  logic [1:0] dac_cmd;
  logic [1:0] adc_cmd;
  logic [1:0] adc_step;
  logic [1:0] adc_busy;
  logic dac_step;
  logic [1:0][7:0] dac_lvl;
  logic [1:0][7:0] adc_lvl;
  logic wr_en;

  // The asynchronous reset is released through two flops.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign wr_en = ctl_valid && reg_mapped(ctl_word.index);
  assign dac_step = fs_tick && (q.div8 == cdr_pkg::FS_PER_STEP_LAST);

  always_comb begin
    // Mute forces the attenuator target to mute; unmute restores the programmed level.
    dac_tgt[0] = q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_MUTE_L] ? cdr_pkg::MUTE_CODE
      : dac_att_left;
    dac_tgt[1] = q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_MUTE_L + 1] ? cdr_pkg::MUTE_CODE
      : dac_att_right;
    for (int c = 0; c < 2; c++) begin
      dac_cmd[c] = (dac_tgt[c] != q.dac_prev[c]);
      adc_cmd[c] = ctl_valid && (ctl_word.index == cdr_pkg::REG_ADC_GAIN_L + 8'(c));
      if (zero_cross_disable) begin
        adc_step[c] = fs_tick && (q.div8 == cdr_pkg::FS_PER_STEP_LAST);
      end else begin
        adc_step[c] = fs_tick && (adc_zero_cross[c]
          || (q.nozc[c] >= cdr_pkg::ZC_TIMEOUT_FS));
      end
    end
  end

  always_comb begin
    logic [7:0] data;
    logic [1:0] zraw;
    data = '0;
    zraw = '0;
    d = q;
    if (wr_en) begin
      data = ctl_word.data & cdr_pkg::REG_MASK[reg_slot(ctl_word.index)];
      d.regs[reg_slot(ctl_word.index)] = data;
    end
    if (fs_tick) begin
      d.div8 = q.div8 + 3'h1;
    end
    for (int c = 0; c < 2; c++) begin
      d.dac_prev[c] = dac_tgt[c];
      if (fs_tick) begin
        if (adc_zero_cross[c]) begin
          d.nozc[c] = '0;
        end else if (q.nozc[c] < cdr_pkg::ZC_TIMEOUT_FS) begin
          d.nozc[c] = q.nozc[c] + 10'h001;
        end
      end
    end
    // Oversampling ratio: base from clock ratio, one step up when the bit is set.
    case (cdr_pkg::cdr_ratio_e'(sysclk_ratio))
      cdr_pkg::CDR_RATIO_512_768: d.osr = cdr_pkg::CDR_OSR_X64;
      cdr_pkg::CDR_RATIO_256_384: d.osr = cdr_pkg::CDR_OSR_X32;
      cdr_pkg::CDR_RATIO_128_192: d.osr = cdr_pkg::CDR_OSR_X16;
      default: d.osr = cdr_pkg::CDR_OSR_X16;
    endcase
    if (q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_OVER]) begin
      d.osr = d.osr + 2'b01;
    end
    if (q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZFUNC]) begin
      zraw = {2{&dac_zero_detect}};
    end else begin
      zraw = dac_zero_detect;
    end
    d.zflag = zraw ^ {2{q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZPOL]}};
    // The reserved rate code falls back to the default rate.
    case (cdr_pkg::cdr_deemph_e'(q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_RATE_LO +: 2]))
      cdr_pkg::CDR_DEEMPH_44K1: d.rate = cdr_pkg::CDR_DEEMPH_44K1;
      cdr_pkg::CDR_DEEMPH_48K: d.rate = cdr_pkg::CDR_DEEMPH_48K;
      cdr_pkg::CDR_DEEMPH_32K: d.rate = cdr_pkg::CDR_DEEMPH_32K;
      default: d.rate = cdr_pkg::CDR_DEEMPH_44K1;
    endcase
    // Reserved interface codes decode as slave.
    case (cdr_pkg::cdr_mode_e'(q.regs[cdr_pkg::SLOT_ADC_CLK][cdr_pkg::B_MODE_LO +: 3]))
      cdr_pkg::CDR_MODE_M768, cdr_pkg::CDR_MODE_M512,
      cdr_pkg::CDR_MODE_M384, cdr_pkg::CDR_MODE_M256: d.master = 1'b1;
      default: d.master = 1'b0;
    endcase
    d.rd_hit = 1'b0;
    if (rd_valid) begin
      d.rd_hit = reg_mapped(rd_index);
      d.rd_data = reg_mapped(rd_index) ? q.regs[reg_slot(rd_index)] : 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{regs: cdr_pkg::REG_RESET, div8: 3'h0, nozc: '0, dac_prev: '0, zflag: 2'b00,
        osr: cdr_pkg::CDR_OSR_X64, rate: cdr_pkg::CDR_DEEMPH_44K1, master: 1'b0,
        rd_data: 8'h00, rd_hit: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  // One pair of ramps per channel: ADC gain and DAC soft mute.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    cdr_ramp #(
      .MUTE_CEIL(cdr_pkg::ADC_MUTE_CEIL),
      .INIT(cdr_pkg::REG_RESET[cdr_pkg::SLOT_ADC_GAIN])
    ) u_adc_ramp (
      .mclk(mclk),
      .ce(ce),
      .rst_n(rst_n),
      .cmd_valid(adc_cmd[c]),
      .cmd_level(ctl_word.data),
      .step(adc_step[c]),
      .level(adc_lvl[c]),
      .busy(adc_busy[c])
    );
    cdr_ramp #(
      .MUTE_CEIL(cdr_pkg::DAC_MUTE_CEIL),
      .INIT(cdr_pkg::MUTE_CODE)
    ) u_dac_ramp (
      .mclk(mclk),
      .ce(ce),
      .rst_n(rst_n),
      .cmd_valid(dac_cmd[c]),
      .cmd_level(dac_tgt[c]),
      .step(dac_step),
      .level(dac_lvl[c]),
      .busy()
    );
  end

  assign rd_data = q.rd_data;
  assign rd_hit = q.rd_hit;
  assign dac_osr_code = q.osr;
  assign dac_phase_invert = q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_PHASE];
  assign dac_left_soft_mute = q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_MUTE_L];
  assign dac_right_soft_mute = q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_MUTE_L + 1];
  assign dac_left_level = dac_lvl[0];
  assign dac_right_level = dac_lvl[1];
  assign filter_rolloff_select = q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ROLLOFF];
  assign deemph_enable = q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_DEEMPH];
  assign deemph_rate_select = q.rate;
  assign left_zero_flag = q.zflag[0];
  assign right_zero_flag = q.zflag[1];
  assign adc_left_level = adc_lvl[0];
  assign adc_right_level = adc_lvl[1];
  assign adc_ramp_busy = |adc_busy;
  assign adc_clock_set_select = q.regs[cdr_pkg::SLOT_ADC_CLK][cdr_pkg::B_CLKSET];
  assign adc_if_mode = q.regs[cdr_pkg::SLOT_ADC_CLK][cdr_pkg::B_MODE_LO +: 3];
  assign adc_master = q.master;

  sequence s_mute_write;
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_DAC_MODE)
      && ctl_word.data[cdr_pkg::B_MUTE_L] && !dac_left_soft_mute && (q.dac_prev[0] != 8'h00);
  endsequence

  sequence s_mute_request;
    dac_cmd[0] && (dac_tgt[0] == cdr_pkg::MUTE_CODE);
  endsequence

  mute_request_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mute_write |=> s_mute_request)
    else $error("Setting left mute did not request a ramp to mute.");

  gain_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_ADC_GAIN_R)
    |=> q.regs[cdr_pkg::SLOT_ADC_GAIN + 1] == $past(ctl_word.data))
    else $error("Right gain write was not stored.");

  phase_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_DAC_MODE)
    |=> dac_phase_invert == $past(ctl_word.data[cdr_pkg::B_PHASE]))
    else $error("Phase select did not follow the written bit.");

  osr_double_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && (sysclk_ratio == cdr_pkg::CDR_RATIO_512_768)
    && q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_OVER] |=> dac_osr_code == cdr_pkg::CDR_OSR_X128)
    else $error("Oversampling did not double at the highest clock ratio.");

  zero_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZFUNC]
    && !q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZPOL] && (dac_zero_detect == 2'b01)
    |=> !left_zero_flag && !right_zero_flag)
    else $error("Combined zero flag raised with one channel live.");

  zero_polar_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZFUNC]
    && q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZPOL] && (dac_zero_detect == 2'b01)
    |=> !left_zero_flag && right_zero_flag)
    else $error("Inverted zero flags wrong for left-only zero.");

  timeout_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !zero_cross_disable && (q.nozc[0] == cdr_pkg::ZC_TIMEOUT_FS) && !adc_zero_cross[0]
    ##1 ce && fs_tick |-> adc_step[0])
    else $error("No per-sample step after the crossing timeout.");

  fixed_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(zero_cross_disable) && (adc_left_level != $past(adc_left_level))
    |-> $past(fs_tick) && ($past(q.div8) == cdr_pkg::FS_PER_STEP_LAST))
    else $error("Gain stepped off the eight-sample grid.");

  rolloff_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_DAC_FILT)
    |=> filter_rolloff_select == $past(ctl_word.data[cdr_pkg::B_ROLLOFF]))
    else $error("Roll-off select did not follow the written bit.");

  deemph_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_DAC_FILT)
    |=> deemph_enable == $past(ctl_word.data[cdr_pkg::B_DEEMPH]))
    else $error("De-emphasis enable did not follow the written bit.");

  clock_set_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_valid && (ctl_word.index == cdr_pkg::REG_ADC_CLK)
    |=> adc_clock_set_select == $past(ctl_word.data[cdr_pkg::B_CLKSET]))
    else $error("Clock set select did not follow the written bit.");

  master_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> adc_master == (($past(adc_if_mode) != cdr_pkg::CDR_MODE_SLAVE)
      && ($past(adc_if_mode) <= cdr_pkg::CDR_MODE_M256)))
    else $error("Master flag does not match the interface mode.");

  rate_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && (q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_RATE_LO +: 2] == cdr_pkg::CDR_DEEMPH_RSV)
    |=> deemph_rate_select == cdr_pkg::CDR_DEEMPH_44K1)
    else $error("Reserved de-emphasis rate did not fall back to the default.");

  zero_plain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZFUNC]
    && !q.regs[cdr_pkg::SLOT_DAC_FILT][cdr_pkg::B_ZPOL]
    |=> {right_zero_flag, left_zero_flag} == $past(dac_zero_detect))
    else $error("Plain zero flags do not follow each channel.");

  osr_base_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && (sysclk_ratio == cdr_pkg::CDR_RATIO_128_192)
    && !q.regs[cdr_pkg::SLOT_DAC_MODE][cdr_pkg::B_OVER]
    |=> dac_osr_code == cdr_pkg::CDR_OSR_X16)
    else $error("Oversampling wrong at the lowest clock ratio.");

  dac_grid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (dac_left_level != $past(dac_left_level)) |-> $past(dac_step))
    else $error("DAC attenuator stepped off the eight-sample grid.");

  adc_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && adc_cmd[0] && !adc_busy[0] && (ctl_word.data != adc_lvl[0]) |=> adc_busy[0])
    else $error("An idle gain ramp did not start on a new level.");

  enable_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ce |=> q == $past(q))
    else $error("State moved while the clock enable was low.");
endmodule : cdr_ctrl_regs

/* hdl/cdr_pkg.sv */
// Shared constants and carrier types for the codec control register set.
package cdr_pkg;
  // Register indices as carried in the upper byte of a control word.
  localparam logic [7:0] REG_DAC_MODE = 8'h44;
  localparam logic [7:0] REG_DAC_FILT = 8'h45;
  localparam logic [7:0] REG_ADC_GAIN_L = 8'h46;
  localparam logic [7:0] REG_ADC_GAIN_R = 8'h47;
  localparam logic [7:0] REG_ADC_CLK = 8'h48;
  localparam logic [7:0] REG_BASE = REG_DAC_MODE;
  localparam int REG_COUNT = 5;
  // Slot numbers inside the register array.
  localparam int SLOT_DAC_MODE = 0;
  localparam int SLOT_DAC_FILT = 1;
  localparam int SLOT_ADC_GAIN = 2;
  localparam int SLOT_ADC_CLK = 4;
  // Reset values and writable bits, slot 4 first.
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {8'h00, 8'hD7, 8'hD7, 8'h00, 8'h00};
  localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {8'hF3, 8'hFF, 8'hFF, 8'hF3, 8'h47};
  // Field positions.
  localparam int B_OVER = 6;
  localparam int B_PHASE = 2;
  localparam int B_MUTE_L = 0;
  localparam int B_ROLLOFF = 7;
  localparam int B_RATE_LO = 5;
  localparam int B_DEEMPH = 4;
  localparam int B_ZPOL = 1;
  localparam int B_ZFUNC = 0;
  localparam int B_CLKSET = 7;
  localparam int B_MODE_LO = 4;
  // Attenuator codes.
  localparam logic [7:0] ADC_MUTE_CEIL = 8'h0E;
  localparam logic [7:0] DAC_MUTE_CEIL = 8'h36;
  localparam logic [7:0] MUTE_CODE = 8'h00;
  // Step timing in sample periods.
  localparam logic [2:0] FS_PER_STEP_LAST = 3'h7;
  localparam logic [9:0] ZC_TIMEOUT_FS = 10'h200;

  typedef enum logic [1:0] {
    CDR_OSR_X16 = 2'b00,
    CDR_OSR_X32 = 2'b01,
    CDR_OSR_X64 = 2'b10,
    CDR_OSR_X128 = 2'b11
  } cdr_osr_e;

  typedef enum logic [1:0] {
    CDR_RATIO_512_768 = 2'b00,
    CDR_RATIO_256_384 = 2'b01,
    CDR_RATIO_128_192 = 2'b10
  } cdr_ratio_e;

  typedef enum logic [1:0] {
    CDR_DEEMPH_44K1 = 2'b00,
    CDR_DEEMPH_48K = 2'b01,
    CDR_DEEMPH_32K = 2'b10,
    CDR_DEEMPH_RSV = 2'b11
  } cdr_deemph_e;

  typedef enum logic [2:0] {
    CDR_MODE_SLAVE = 3'b000,
    CDR_MODE_M768 = 3'b001,
    CDR_MODE_M512 = 3'b010,
    CDR_MODE_M384 = 3'b011,
    CDR_MODE_M256 = 3'b100
  } cdr_mode_e;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } cdr_ctl_word_s;
endpackage : cdr_pkg

/* hdl/cdr_ramp.sv */
// Stepping attenuator with a single buffered level command.
`timescale 1ns/10ps
module cdr_ramp #(
  parameter logic [7:0] MUTE_CEIL = 8'h00,
  parameter logic [7:0] INIT = 8'h00
) (
  // Clock, enable and reset.
  input wire logic mclk,
  input wire logic ce,
  input wire logic rst_n,
  // Level command and step timing.
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_level,
  input wire logic step,
  // Ramp state.
  output logic [7:0] level,
  output logic busy
);
  typedef enum logic [0:0] {
    CDR_RMP_IDLE = 1'b0,
    CDR_RMP_RUN = 1'b1
  } cdr_rmp_state_e;

  typedef struct packed {
    cdr_rmp_state_e st;
    logic [7:0] level;
    logic [7:0] target;
    logic [7:0] pend;
    logic pend_v;
  } cdr_rmp_s;

  cdr_rmp_s q, d;

  always_comb begin
    d = q;
    case (q.st)
      CDR_RMP_IDLE: begin
        if (cmd_valid) begin
          d.target = cmd_level;
          d.st = (cmd_level != q.level) ? CDR_RMP_RUN : CDR_RMP_IDLE;
        end
      end
      CDR_RMP_RUN: begin
        if (cmd_valid) begin
          d.pend = cmd_level;
          d.pend_v = 1'b1;
        end
        if (step) begin
          if (q.target < q.level) begin
            d.level = (q.level <= MUTE_CEIL + 8'h01) ? q.target : q.level - 8'h01;
          end else begin
            if (q.target <= MUTE_CEIL) begin
              d.level = q.target;
            end else begin
              d.level = (q.level < MUTE_CEIL) ? MUTE_CEIL + 8'h01 : q.level + 8'h01;
            end
          end
          if (d.level == q.target) begin
            d.st = CDR_RMP_IDLE;
            if (d.pend_v) begin
              d.target = d.pend;
              d.pend_v = 1'b0;
              d.st = (d.pend != d.level) ? CDR_RMP_RUN : CDR_RMP_IDLE;
            end
          end
        end
      end
      default: d.st = CDR_RMP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: CDR_RMP_IDLE, level: INIT, target: INIT, pend: INIT, pend_v: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign level = q.level;
  assign busy = (q.st == CDR_RMP_RUN);

  step_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q.level != $past(q.level) |-> $past(step) && $past(ce))
    else $error("Attenuator level moved without a step strike.");

  step_size_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(q.level) > MUTE_CEIL + 8'h01) && (q.level < $past(q.level))
    |-> q.level == $past(q.level) - 8'h01)
    else $error("Attenuator stepped down by more than one code.");

  hold_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && busy && cmd_valid && !step |=> q.target == $past(q.target) && q.pend_v)
    else $error("A command during a ramp disturbed the running target.");
endmodule : cdr_ramp

/* testbench/cdr_host_model.sv */
// Host controller model that issues control words and register reads.
`timescale 1ns/10ps
module cdr_host_model (
  // Clock.
  input wire logic mclk,
  // Control port.
  output cdr_pkg::cdr_ctl_word_s ctl_word,
  output logic ctl_valid,
  output logic rd_valid,
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  initial begin
    ctl_word = '0;
    ctl_valid = 1'b0;
    rd_valid = 1'b0;
    rd_index = 8'h00;
  end

  // Sends one word over one rising edge; oversampling writes are never held back here.
  task automatic wr(input logic [7:0] index, input logic [7:0] data);
    @(negedge mclk);
    ctl_word = '{index: index, data: data};
    ctl_valid = 1'b1;
    @(negedge mclk);
    ctl_valid = 1'b0;
    ctl_word = ~ctl_word;
  endtask : wr

  // Reads one register; the answer is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] index, output logic [7:0] data, output logic hit);
    @(negedge mclk);
    rd_index = index;
    rd_valid = 1'b1;
    @(negedge mclk);
    rd_valid = 1'b0;
    rd_index = ~rd_index;
    data = rd_data;
    hit = rd_hit;
  endtask : rd
endmodule : cdr_host_model

/* testbench/test_cdr_ctrl_regs.sv */
// Self-checking bench for the codec control register set.
`timescale 1ns/10ps
module test_cdr_ctrl_regs;
  localparam logic [5:0][7:0] RST_EXP = {8'h00, 8'h00, 8'hD7, 8'hD7, 8'h00, 8'h00};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic fs_tick = 1'b0;
  logic [1:0] fs_cnt = 2'h0;
  logic [1:0] sysclk_ratio = 2'h0;
  logic zero_cross_disable = 1'b1;
  logic [1:0] adc_zero_cross = 2'h0;
  logic [1:0] dac_zero_detect = 2'h0;
  logic [7:0] dac_att_left = 8'h3A;
  logic [7:0] dac_att_right = 8'h3A;
  cdr_pkg::cdr_ctl_word_s ctl_word;
  logic ctl_valid, rd_valid, rd_hit, dac_phase_invert, dac_left_soft_mute;
  logic dac_right_soft_mute, filter_rolloff_select, deemph_enable, left_zero_flag;
  logic right_zero_flag, adc_ramp_busy, adc_clock_set_select, adc_master;
  logic [7:0] rd_index, rd_data, dac_left_level, dac_right_level, adc_left_level;
  logic [7:0] adc_right_level;
  logic [1:0] dac_osr_code, deemph_rate_select;
  logic [2:0] adc_if_mode;
  int err_total = 0;
  int n_checks = 0;

  cdr_host_model host_u (.mclk, .ctl_word, .ctl_valid, .rd_valid, .rd_index, .rd_data,
    .rd_hit);

  cdr_ctrl_regs dut_u (.mclk, .rstn, .ce, .ctl_valid, .ctl_word, .rd_valid, .rd_index,
    .rd_data, .rd_hit, .fs_tick, .sysclk_ratio, .zero_cross_disable, .adc_zero_cross,
    .dac_zero_detect, .dac_att_left, .dac_att_right, .dac_osr_code, .dac_phase_invert,
    .dac_left_soft_mute, .dac_right_soft_mute, .dac_left_level, .dac_right_level,
    .filter_rolloff_select, .deemph_enable, .deemph_rate_select, .left_zero_flag,
    .right_zero_flag, .adc_left_level, .adc_right_level, .adc_ramp_busy,
    .adc_clock_set_select, .adc_if_mode, .adc_master);

  always #5 mclk = ~mclk;

  // One sample period every four clocks.
  always @(negedge mclk) begin
    fs_cnt <= fs_cnt + 2'h1;
    fs_tick <= (fs_cnt == 2'h3);
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask : settle

  function automatic logic [7:0] lvl(input int s);
    case (s)
      0: return adc_left_level;
      1: return adc_right_level;
      2: return dac_left_level;
      default: return dac_right_level;
    endcase
  endfunction : lvl

  // Waits for a level to reach a value, then compares it.
  task automatic wait_lvl(input int s, input logic [7:0] t, input int lim);
    int n = 0;
    while (lvl(s) !== t && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk("ramp level", lvl(s), t);
  endtask : wait_lvl

  // Cycles until the first level change, then cycles between the first two changes.
  task automatic gap(input int s, input int lim, output int w, output int g);
    logic [7:0] v;
    v = lvl(s);
    w = 0;
    while (lvl(s) === v && w < lim) begin
      @(negedge mclk);
      w++;
    end
    v = lvl(s);
    g = 0;
    while (lvl(s) === v && g < lim) begin
      @(negedge mclk);
      g++;
    end
  endtask : gap

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    results();
  end

  initial begin
    logic [7:0] d;
    logic h;
    logic [1:0] z;
    int w, g;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    repeat (6) @(negedge mclk);
    // Reset values, then an unmapped index.
    for (int i = 0; i < 6; i++) begin
      host_u.rd(8'(8'h44 + i), d, h);
      chk("read data", d, RST_EXP[i]);
      chk("read hit", 8'(h), 8'(i < 5));
    end
    chk("osr", 8'(dac_osr_code), 8'h02);
    chk("phase", 8'(dac_phase_invert), 8'h00);
    chk("rolloff", 8'(filter_rolloff_select), 8'h00);
    chk("deemph on", 8'(deemph_enable), 8'h00);
    chk("clock set", 8'(adc_clock_set_select), 8'h00);
    chk("master", 8'(adc_master), 8'h00);
    // Oversampling ratio for each clock ratio.
    for (int r = 0; r < 3; r++) begin
      for (int o = 0; o < 2; o++) begin
        sysclk_ratio = 2'(r);
        host_u.wr(8'h44, 8'(o << 6));
        settle();
        chk("osr", 8'(dac_osr_code), 8'(2 - r + o));
      end
    end
    // De-emphasis rates with the filter on.
    for (int i = 0; i < 3; i++) begin
      host_u.wr(8'h45, 8'((i << 5) | 8'h10));
      settle();
      chk("deemph rate", 8'(deemph_rate_select), 8'(i));
      chk("deemph on", 8'(deemph_enable), 8'h01);
    end
    // Every interface mode code.
    for (int i = 0; i < 8; i++) begin
      host_u.wr(8'h48, 8'(i << 4));
      settle();
      chk("if mode", 8'(adc_if_mode), 8'(i));
      chk("master", 8'(adc_master), 8'(i >= 1 && i <= 4));
    end
    // Zero flags over every polarity, function and detect pattern.
    for (int k = 0; k < 16; k++) begin
      host_u.wr(8'h45, 8'(k[3:2]));
      dac_zero_detect = 2'(k);
      settle();
      z = k[2] ? {2{&k[1:0]}} : 2'(k);
      z = k[3] ? ~z : z;
      chk("left flag", 8'(left_zero_flag), 8'(z[0]));
      chk("right flag", 8'(right_zero_flag), 8'(z[1]));
    end
    // DAC soft mute down on both channels and back up on the left.
    wait_lvl(2, 8'h3A, 500);
    wait_lvl(3, 8'h3A, 500);
    host_u.wr(8'h44, 8'h03);
    gap(2, 100, w, g);
    chk("dac step", 8'(g), 8'd32);
    wait_lvl(2, 8'h00, 400);
    wait_lvl(3, 8'h00, 400);
    host_u.wr(8'h44, 8'h00);
    wait_lvl(2, 8'h3A, 500);
    // ADC ramp on the fixed grid, with commands arriving mid-ramp.
    host_u.wr(8'h46, 8'hD4);
    @(negedge mclk);
    chk("busy", 8'(adc_ramp_busy), 8'h01);
    gap(0, 100, w, g);
    chk("adc step", 8'(g), 8'd32);
    host_u.wr(8'h46, 8'hD0);
    host_u.wr(8'h46, 8'hD9);
    wait_lvl(0, 8'hD4, 100);
    wait_lvl(0, 8'hD9, 300);
    // Steps at crossings, then the no-crossing timeout.
    zero_cross_disable = 1'b0;
    adc_zero_cross = 2'b11;
    host_u.wr(8'h47, 8'hD4);
    gap(1, 50, w, g);
    chk("cross step", 8'(g), 8'd4);
    adc_zero_cross = 2'b10;
    host_u.wr(8'h46, 8'hD7);
    gap(0, 2400, w, g);
    chk("timeout wait", 8'(w >= 2030 && w <= 2060), 8'h01);
    chk("timeout step", 8'(g), 8'd4);
    // Writable bits and the decoded outputs of all-ones writes.
    host_u.wr(8'h44, 8'hFF);
    host_u.wr(8'h45, 8'hFF);
    host_u.wr(8'h48, 8'hFF);
    settle();
    host_u.rd(8'h44, d, h);
    chk("reg 44", d, 8'h47);
    host_u.rd(8'h45, d, h);
    chk("reg 45", d, 8'hF3);
    host_u.rd(8'h48, d, h);
    chk("reg 48", d, 8'hF3);
    chk("phase", 8'(dac_phase_invert), 8'h01);
    chk("mutes", 8'({dac_right_soft_mute, dac_left_soft_mute}), 8'h03);
    chk("rolloff", 8'(filter_rolloff_select), 8'h01);
    chk("deemph rate", 8'(deemph_rate_select), 8'h00);
    chk("clock set", 8'(adc_clock_set_select), 8'h01);
    chk("master", 8'(adc_master), 8'h00);
    // A write while the clock enable is low leaves every register alone.
    ce = 1'b0;
    host_u.wr(8'h48, 8'h00);
    settle();
    ce = 1'b1;
    chk("frozen clock set", 8'(adc_clock_set_select), 8'h01);
    host_u.wr(8'h46, 8'h0E);
    host_u.rd(8'h46, d, h);
    chk("reg 46", d, 8'h0E);
    wait_lvl(0, 8'h0E, 1000);
    results();
  end
endmodule : test_cdr_ctrl_regs
